// File: hw/motor_overheat_fan_control.sv
module motor_overheat_fan_control #(
  parameter int TICK_CYC = ptc_pkg::TICK_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [9:0] thermistor_analog_input,
  input wire logic drive_running,
  output logic motor_overheat_alarm,
  output logic motor_overheat_fault,
  output logic alarm_indicator,
  output logic fault_indicator,
  output logic setting_error_code,
  output logic stop_decel_normal,
  output logic stop_decel_two,
  output logic stop_coast,
  output logic fan_on,
  output logic irq
);

  typedef struct packed {
    ptc_pkg::bus_st_t bus;
    logic [5:0] ph_addr;
    logic ph_panel;
    logic rdy;
    logic resp;
    logic [31:0] rdata;
    logic [2:0] prot_sel;
    logic [6:0] filt_time;
    logic [3:0] freq_ref;
    logic [1:0] pid_sel;
    logic [2:0] pid_fb;
    logic fan_mode;
    logic [16:0] tick_cnt;
    logic tick;
    logic [6:0] step_cnt;
    logic [15:0] filt;
    logic alarm;
    logic fault;
    ptc_pkg::stop_t stop;
    logic [2:0] stop_pin;
    logic [15:0] fan_cnt;
    logic fan;
    logic [8:0] blink_cnt;
    logic blink;
    logic alarm_led;
    logic fault_led;
    logic set_err;
    logic err_led;
    logic [3:0] int_stat;
    logic [3:0] int_mask;
    logic irq;
  } state_t;

  localparam state_t RESET_STATE = '{
    bus: ptc_pkg::BUS_IDLE,
    stop: ptc_pkg::STOP_NONE,
    rdy: 1'b1,
    filt_time: ptc_pkg::FILT_RST,
    prot_sel: ptc_pkg::SEL_OFF,
    default: '0
  };

  state_t q;
  state_t n;
  logic signed [16:0] diff;
  logic [9:0] code;
  logic above_alarm;
  logic above_fault;
  logic enabled;
  logic sel_alarm;
  logic sel_stop;
  logic accept;
  logic reject;
  logic rd_clear;
  logic ref_ana;
  logic fb_ana;
  logic [3:0] ev;
  logic [31:0] wd;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = q;
    diff = '0;
    reject = 1'b0;
    rd_clear = 1'b0;
    ev = '0;
    wd = hwdata;
    code = q.filt[15:6];
    above_alarm = code > ptc_pkg::ALARM_CODE;
    above_fault = code > ptc_pkg::FAULT_CODE;
    enabled = q.prot_sel != ptc_pkg::SEL_OFF;
    sel_alarm = enabled && q.prot_sel <= ptc_pkg::SEL_A_COAST;
    sel_stop = q.prot_sel >= ptc_pkg::SEL_A_DEC1;
    ref_ana = q.freq_ref >= 4'(ptc_pkg::REF_ANA_LO) && q.freq_ref <= 4'(ptc_pkg::REF_ANA_HI);
    fb_ana = q.pid_fb <= 3'(ptc_pkg::FB_ANA_HI);
    accept = hsel && hready && htrans[1];

    // one shared time base keeps every slow counter in step
    n.tick = 1'b0;
    if (q.tick_cnt == 17'(TICK_CYC - 1)) begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = q.tick_cnt + 17'h00001;
    end

    // 64 steps of 1/64 each make one time constant
    if (q.filt_time == 7'h00) begin
      n.filt = {thermistor_analog_input, 6'h00};
      n.step_cnt = '0;
    end else if (q.tick) begin
      if (q.step_cnt >= 7'(q.filt_time * ptc_pkg::STEP_PER_UNIT - 1)) begin
        n.step_cnt = '0;
        diff = $signed({1'b0, thermistor_analog_input, 6'h00}) - $signed({1'b0, q.filt});
        n.filt = q.filt + 16'(diff >>> ptc_pkg::FILT_SHIFT);
      end else begin
        n.step_cnt = q.step_cnt + 7'h01;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus data phase
    case (q.bus)
      ptc_pkg::BUS_WRITE: begin
        case (q.ph_addr)
          ptc_pkg::A_PROT: begin
            if (wd == 32'(ptc_pkg::SEL_ALARM) && ref_ana && q.pid_sel == 2'h1 && fb_ana) begin
              reject = 1'b1;
            end else begin
              n.prot_sel = wd[2:0];
            end
          end
          ptc_pkg::A_FILT: begin
            if (wd > 32'(ptc_pkg::FILT_MAX)) begin
              reject = 1'b1;
            end else begin
              n.filt_time = wd[6:0];
            end
          end
          ptc_pkg::A_FREF: begin
            if (wd > ptc_pkg::REF_MAX) begin
              reject = 1'b1;
            end else if (enabled && wd >= ptc_pkg::REF_ANA_LO && wd <= ptc_pkg::REF_ANA_HI) begin
              reject = 1'b1;
            end else begin
              n.freq_ref = wd[3:0];
            end
          end
          ptc_pkg::A_PIDS: begin
            n.pid_sel = wd[1:0];
          end
          ptc_pkg::A_PIDF: begin
            if (q.pid_sel != 2'h0 && wd <= ptc_pkg::FB_ANA_HI) begin
              reject = 1'b1;
            end else begin
              n.pid_fb = wd[2:0];
            end
          end
          ptc_pkg::A_FAN: begin
            n.fan_mode = wd[0];
          end
          ptc_pkg::A_IMASK: begin
            n.int_mask = wd[3:0];
          end
          ptc_pkg::A_CLR: begin
            // a clear command releases a latched fault only once the winding has cooled
            if (wd[ptc_pkg::CLR_FAULT] && !above_fault) begin
              n.fault = 1'b0;
            end
            if (wd[ptc_pkg::CLR_SETERR]) begin
              n.set_err = 1'b0;
            end
          end
          default: begin
          end
        endcase
        // a refused write leaves the old value standing
        if (reject && q.ph_panel) begin
          ev[ptc_pkg::IB_PANEL] = 1'b1;
        end else if (reject) begin
          n.set_err = 1'b1;
          ev[ptc_pkg::IB_SETERR] = 1'b1;
        end
        n.bus = ptc_pkg::BUS_IDLE;
      end
      ptc_pkg::BUS_READ: begin
        n.rdata = '0;
        case (q.ph_addr)
          ptc_pkg::A_PROT: n.rdata = 32'(q.prot_sel);
          ptc_pkg::A_FILT: n.rdata = 32'(q.filt_time);
          ptc_pkg::A_FREF: n.rdata = 32'(q.freq_ref);
          ptc_pkg::A_PIDS: n.rdata = 32'(q.pid_sel);
          ptc_pkg::A_PIDF: n.rdata = 32'(q.pid_fb);
          ptc_pkg::A_FAN: n.rdata = 32'(q.fan_mode);
          ptc_pkg::A_STAT: begin
            n.rdata[9:0] = code;
            n.rdata[ptc_pkg::ST_ALARM] = q.alarm;
            n.rdata[ptc_pkg::ST_FAULT] = q.fault;
            n.rdata[ptc_pkg::ST_FAN] = q.fan;
            n.rdata[ptc_pkg::ST_SETERR] = q.set_err;
            n.rdata[ptc_pkg::ST_STOP +: 2] = q.stop;
          end
          ptc_pkg::A_ISTAT: begin
            n.rdata = 32'(q.int_stat);
            rd_clear = 1'b1;
          end
          ptc_pkg::A_IMASK: n.rdata = 32'(q.int_mask);
          default: n.rdata = '0;
        endcase
        n.rdy = 1'b1;
        n.bus = ptc_pkg::BUS_IDLE;
      end
      default: begin
        n.bus = ptc_pkg::BUS_IDLE;
      end
    endcase

    // address phase; reads take one wait state so a prior write is seen
    if (accept) begin
      n.ph_addr = haddr[5:0];
      n.ph_panel = haddr[ptc_pkg::PANEL_BIT];
      n.bus = hwrite ? ptc_pkg::BUS_WRITE : ptc_pkg::BUS_READ;
      n.rdy = hwrite;
    end

    ////////////////////////////////////////////////////////////////////////
    // supervision
    n.alarm = sel_alarm && above_alarm;
    if (!sel_stop) begin
      n.fault = 1'b0;
    end else if (above_fault) begin
      n.fault = 1'b1;
    end
    n.stop = ptc_pkg::STOP_NONE;
    if (n.fault) begin
      case (q.prot_sel)
        ptc_pkg::SEL_A_DEC1, ptc_pkg::SEL_N_DEC1: n.stop = ptc_pkg::STOP_DECEL1;
        ptc_pkg::SEL_A_DEC2, ptc_pkg::SEL_N_DEC2: n.stop = ptc_pkg::STOP_DECEL2;
        default: n.stop = ptc_pkg::STOP_COAST;
      endcase
    end
    // decoded here so each stop pin leaves a flop of its own
    n.stop_pin[0] = n.stop == ptc_pkg::STOP_DECEL1;
    n.stop_pin[1] = n.stop == ptc_pkg::STOP_DECEL2;
    n.stop_pin[2] = n.stop == ptc_pkg::STOP_COAST;

    if (q.tick) begin
      if (q.blink_cnt == ptc_pkg::BLINK_TICKS - 9'h001) begin
        n.blink_cnt = '0;
        n.blink = !q.blink;
      end else begin
        n.blink_cnt = q.blink_cnt + 9'h001;
      end
    end
    n.alarm_led = n.alarm && n.blink;
    n.fault_led = n.fault && n.blink;
    n.err_led = n.set_err && n.blink;

    // fan run-on reloads while running, counts down after stop
    if (drive_running) begin
      n.fan_cnt = ptc_pkg::FAN_HOLD_TICKS;
    end else if (q.tick && q.fan_cnt != 16'h0000) begin
      n.fan_cnt = q.fan_cnt - 16'h0001;
    end
    n.fan = q.fan_mode || drive_running || n.fan_cnt != 16'h0000;

    ev[ptc_pkg::IB_ALARM] = n.alarm && !q.alarm;
    ev[ptc_pkg::IB_FAULT] = n.fault && !q.fault;
    if (rd_clear) begin
      n.int_stat = '0;
    end
    n.int_stat = n.int_stat | ev;
    n.irq = |(n.int_stat & n.int_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= RESET_STATE;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign hreadyout = q.rdy;
  assign hresp = q.resp;
  assign hrdata = q.rdata;
  assign motor_overheat_alarm = q.alarm;
  assign motor_overheat_fault = q.fault;
  assign alarm_indicator = q.alarm_led;
  assign fault_indicator = q.fault_led;
  assign setting_error_code = q.err_led;
  assign stop_decel_normal = q.stop_pin[0];
  assign stop_decel_two = q.stop_pin[1];
  assign stop_coast = q.stop_pin[2];
  assign fan_on = q.fan;
  assign irq = q.irq;

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  alarm_cause_a: assert property (
    $rose(q.alarm) |-> $past(code > ptc_pkg::ALARM_CODE && sel_alarm))
    else $error("alarm rose without cause");

  fault_cause_a: assert property (
    $rose(q.fault) |-> $past(code > ptc_pkg::FAULT_CODE && sel_stop))
    else $error("fault rose without cause");

  reset_sel_a: assert property (
    $rose(hresetn) |-> q.prot_sel == ptc_pkg::SEL_OFF)
    else $error("selection not zero after reset");

  alarm_only_a: assert property (
    (q.prot_sel == ptc_pkg::SEL_ALARM) [*2] |-> !q.fault && q.stop == ptc_pkg::STOP_NONE)
    else $error("alarm-only selection stopped the motor");

  coast_map_a: assert property (
    stop_coast |-> q.fault
    && $past(q.prot_sel == ptc_pkg::SEL_A_COAST || q.prot_sel == ptc_pkg::SEL_N_COAST))
    else $error("coast stop with wrong selection");

  no_alarm_a: assert property (
    (q.prot_sel >= ptc_pkg::SEL_N_DEC1) [*2] |-> !q.alarm)
    else $error("alarm shown while suppressed");

  filt_pass_a: assert property (
    q.filt_time == 7'h00 |=> q.filt[15:6] == $past(thermistor_analog_input))
    else $error("zero time constant not pass-through");

  filt_range_a: assert property (
    q.filt_time <= ptc_pkg::FILT_MAX)
    else $error("time constant out of range");

  ref_lock_a: assert property (
    (q.bus == ptc_pkg::BUS_WRITE && q.ph_addr == ptc_pkg::A_FREF && enabled
     && hwdata >= ptc_pkg::REF_ANA_LO && hwdata <= ptc_pkg::REF_ANA_HI)
    |=> $stable(q.freq_ref))
    else $error("analogue reference accepted");

  fb_lock_a: assert property (
    (q.bus == ptc_pkg::BUS_WRITE && q.ph_addr == ptc_pkg::A_PIDF && q.pid_sel != 2'h0
     && hwdata <= ptc_pkg::FB_ANA_HI) |=> $stable(q.pid_fb))
    else $error("analogue feedback accepted");

  panel_keep_a: assert property (
    (reject && q.ph_panel) |=> $stable(q.prot_sel) && q.int_stat[ptc_pkg::IB_PANEL])
    else $error("panel refusal not flagged");

  bus_err_a: assert property (
    (reject && !q.ph_panel) |=> q.set_err ##1 q.set_err)
    else $error("setting error not raised");

  fan_hold_a: assert property (
    ($fell(drive_running) && !q.fan_mode) |=> q.fan [*8])
    else $error("fan stopped without run-on");

  fan_cont_a: assert property (
    q.fan_mode |=> q.fan)
    else $error("fan off in continuous mode");

  read_wait_a: assert property (
    (accept && !hwrite) |=> !q.rdy ##1 q.rdy)
    else $error("read wait state wrong");

  fault_cov: cover property ($rose(q.fault) ##1 stop_decel_two);
  alarm_cov: cover property ($rose(q.alarm) ##1 q.irq);
  reject_cov: cover property (reject && !q.ph_panel);
  fan_cov: cover property ($fell(drive_running) ##1 q.fan);

endmodule

// File: hw/ptc_pkg.sv
// Functional notes
// - filtered input above 0.94 V raises the flashing overheat alarm, operation continues.
// - filtered input above 1.87 V declares the flashing overheat fault and stops.
// - selection of one or more enables supervision and reserves the analogue input.
// - protection selection resets to zero, supervision disabled.
// - selection one flags the alarm only and never stops the motor.
// - fault stop is normal deceleration, deceleration time two, or coast, with fault output.
// - each stop method exists with the alarm flagged and with the alarm suppressed.
// - input low-pass filter, 0.0 to 10.0 s in 0.1 s steps, default 0.2 s.
// - with protection enabled, frequency reference sources 2, 3 and 4 are refused.
// - with PID control on, feedback sources 0, 1 and 2 are refused.
// - selection 1 refused while reference 2-4 and PID 1 with feedback 0-2.
// - refused panel write shows an error and keeps the previous value.
// - refused serial-bus write raises a flashing constant setting error.
// - fan mode 0 runs the fan with the drive and one minute after stopping.
// - fan mode 1 runs the fan continuously while powered.
package ptc_pkg;
  localparam int CLK_NS = 20;
  localparam int TICK_NS = 1562500;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam longint FAN_HOLD_MS = 60000;
  localparam logic [15:0] FAN_HOLD_TICKS = 16'(FAN_HOLD_MS * 1000000 / TICK_NS);
  localparam int BLINK_MS = 500;
  localparam logic [8:0] BLINK_TICKS = 9'(BLINK_MS * 1000000 / TICK_NS);
  localparam int FILT_SHIFT = 6;
  localparam int FILT_UNIT_MS = 100;
  localparam int STEP_PER_UNIT = FILT_UNIT_MS * 1000000 / (TICK_NS * (1 << FILT_SHIFT));
  localparam logic [6:0] FILT_MAX = 7'h64;
  localparam logic [6:0] FILT_RST = 7'h02;
  localparam int ADC_FS_MV = 10000;
  localparam int ADC_MAX = 1023;
  localparam int ALARM_MV = 940;
  localparam int FAULT_MV = 1870;
  localparam logic [9:0] ALARM_CODE = 10'(ALARM_MV * ADC_MAX / ADC_FS_MV);
  localparam logic [9:0] FAULT_CODE = 10'(FAULT_MV * ADC_MAX / ADC_FS_MV);
  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_ALARM = 3'h1;
  localparam logic [2:0] SEL_A_DEC1 = 3'h2;
  localparam logic [2:0] SEL_A_DEC2 = 3'h3;
  localparam logic [2:0] SEL_A_COAST = 3'h4;
  localparam logic [2:0] SEL_N_DEC1 = 3'h5;
  localparam logic [2:0] SEL_N_DEC2 = 3'h6;
  localparam logic [2:0] SEL_N_COAST = 3'h7;
  localparam logic [31:0] REF_MAX = 32'h0000_0009;
  localparam logic [31:0] REF_ANA_LO = 32'h0000_0002;
  localparam logic [31:0] REF_ANA_HI = 32'h0000_0004;
  localparam logic [31:0] FB_ANA_HI = 32'h0000_0002;
  localparam logic [5:0] A_PROT = 6'h00;
  localparam logic [5:0] A_FILT = 6'h04;
  localparam logic [5:0] A_FREF = 6'h08;
  localparam logic [5:0] A_PIDS = 6'h0C;
  localparam logic [5:0] A_PIDF = 6'h10;
  localparam logic [5:0] A_FAN = 6'h14;
  localparam logic [5:0] A_STAT = 6'h18;
  localparam logic [5:0] A_ISTAT = 6'h1C;
  localparam logic [5:0] A_IMASK = 6'h20;
  localparam logic [5:0] A_CLR = 6'h24;
  localparam int PANEL_BIT = 6;
  localparam int ST_ALARM = 16;
  localparam int ST_FAULT = 17;
  localparam int ST_FAN = 18;
  localparam int ST_SETERR = 19;
  localparam int ST_STOP = 20;
  localparam int IB_ALARM = 0;
  localparam int IB_FAULT = 1;
  localparam int IB_SETERR = 2;
  localparam int IB_PANEL = 3;
  localparam int CLR_FAULT = 0;
  localparam int CLR_SETERR = 1;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} bus_st_t;
  typedef enum logic [1:0] {STOP_NONE, STOP_DECEL1, STOP_DECEL2, STOP_COAST} stop_t;
endpackage

// File: testbench/ptc_string_model.sv
module ptc_string_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [9:0] phase_a,
  input wire logic [9:0] phase_b,
  input wire logic [9:0] phase_c,
  output logic [9:0] string_code
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] sum;
  // windings in series, so the three drops add; hotter windings give a larger drop
  assign sum = 12'(phase_a) + 12'(phase_b) + 12'(phase_c);
  // clipped at converter full scale, a wrapped sum would read as a cold motor
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      string_code <= 10'h000;
    end else begin
      string_code <= (sum > 12'h3FF) ? 10'h3FF : sum[9:0];
    end
  end
endmodule

// File: testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK = 2;
  localparam int HOLD_CYC = int'(ptc_pkg::FAN_HOLD_TICKS) * TICK;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, drive_running, rd_phase;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [9:0] ph_a, ph_b, ph_c, tcode;
  logic al, flt, al_ind, flt_ind, set_err, st_n, st_2, st_c, fan_on, irq;
  logic [31:0] exp_q[$];
  string name_q[$];
  int fails, total_checks, na, nf;
  assign hready = hreadyout;

  motor_overheat_fan_control #(.TICK_CYC(TICK)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .thermistor_analog_input(tcode), .drive_running(drive_running),
    .motor_overheat_alarm(al), .motor_overheat_fault(flt), .alarm_indicator(al_ind),
    .fault_indicator(flt_ind), .setting_error_code(set_err), .stop_decel_normal(st_n),
    .stop_decel_two(st_2), .stop_coast(st_c), .fan_on(fan_on), .irq(irq));
  ptc_string_model sensor (.hclk(hclk), .hresetn(hresetn), .phase_a(ph_a), .phase_b(ph_b),
    .phase_c(ph_c), .string_code(tcode));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

////////////////////////////////////////////////////////////////////////////////
  task automatic check_word(input string w, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic check_pin(input string w, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", w, e, g);
    end
  endtask

  task automatic give_verdict();
    if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // looks at hreadyout mid-cycle so the sampling edge never races the slave's flops
  task automatic wait_rdy();
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        give_verdict();
      end
      @(negedge hclk);
    end
    @(posedge hclk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic p = 1'b0);
    hsel <= 1'b1;
    haddr <= {25'h0000000, p, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string w);
    exp_q.push_back(e);
    name_q.push_back(w);
    hsel <= 1'b1;
    haddr <= {26'h0000000, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    wait_rdy();
    htrans <= 2'h0;
    rd_phase <= 1'b1;
    wait_rdy();
    rd_phase <= 1'b0;
  endtask

  // read data stands from hreadyout's return until the master's sampling edge
  always @(negedge hclk) begin
    if (rd_phase && hreadyout === 1'b1) check_word(name_q.pop_front(), exp_q.pop_front(), hrdata);
  end

  // random split over the three windings, same string total
  task automatic apply(input logic [9:0] code);
    logic [9:0] a, b;
    a = 10'($urandom_range(int'(code)));
    b = 10'($urandom_range(int'(code - a)));
    ph_a <= a;
    ph_b <= b;
    ph_c <= code - a - b;
    repeat (6) @(posedge hclk);
  endtask

  task automatic pins(input logic ea, input logic ef, input logic en, input logic e2,
                      input logic ec);
    repeat (2) @(posedge hclk);
    check_pin("alarm", ea, al);
    check_pin("fault", ef, flt);
    check_pin("stop_decel_normal", en, st_n);
    check_pin("stop_decel_two", e2, st_2);
    check_pin("stop_coast", ec, st_c);
  endtask

////////////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    ph_a = 10'h000;
    ph_b = 10'h000;
    ph_c = 10'h000;
    drive_running = 1'b0;
    rd_phase = 1'b0;
    fails = 0;
    total_checks = 0;
    void'($urandom(32'hD93397EA));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ptc_pkg::A_PROT, 32'h0, "prot_sel");
    rd(ptc_pkg::A_FILT, 32'h2, "filt_time");
    check_pin("hresp", 1'b0, hresp);
    wr(ptc_pkg::A_FILT, 32'h0);
    apply(10'h0FA);
    pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    for (int s = 1; s <= 7; s++) begin
      wr(ptc_pkg::A_PROT, 32'(s));
      rd(ptc_pkg::A_PROT, 32'(s), "prot_sel");
      apply(10'h060);
      pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      apply(10'h061);
      pins(s <= 4, 1'b0, 1'b0, 1'b0, 1'b0);
      apply(10'h0BF);
      pins(s <= 4, 1'b0, 1'b0, 1'b0, 1'b0);
      apply(10'h0C0);
      pins(s <= 4, s >= 2, s == 2 || s == 5, s == 3 || s == 6,
           s == 4 || s == 7);
      if (s == 2) begin
        na = 0;
        nf = 0;
        for (int i = 0; i < 1400; i++) begin
          @(posedge hclk);
          na += int'(al_ind === 1'b1);
          nf += int'(flt_ind === 1'b1);
        end
        check_pin("alarm flashing", 1'b1, na > 0 && na < 1400);
        check_pin("fault flashing", 1'b1, nf > 0 && nf < 1400);
        rd(ptc_pkg::A_STAT, 32'h001300C0, "status");
      end
      apply(10'h000);
      pins(1'b0, s >= 2, s == 2 || s == 5, s == 3 || s == 6, s == 4 || s == 7);
      wr(ptc_pkg::A_CLR, 32'h1);
      pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    end
    // one-tenth second constant: about seven steps to pass the alarm level
    wr(ptc_pkg::A_PROT, 32'h1);
    wr(ptc_pkg::A_FILT, 32'h1);
    apply(10'h3FF);
    check_pin("alarm filtered", 1'b0, al);
    repeat (40) @(posedge hclk);
    check_pin("alarm filtered", 1'b1, al);
    wr(ptc_pkg::A_FILT, 32'h0);
    apply(10'h000);
    rd(ptc_pkg::A_ISTAT, 32'h3, "int_stat");
////////////////////////////////////////////////////////////////////////////////
    wr(ptc_pkg::A_IMASK, 32'hC);
    for (int f = 2; f <= 4; f++) begin
      wr(ptc_pkg::A_FREF, 32'(f));
      rd(ptc_pkg::A_FREF, 32'h0, "freq_ref");
    end
    check_pin("irq", 1'b1, irq);
    rd(ptc_pkg::A_STAT, 32'h00080000, "status");
    na = 0;
    for (int i = 0; i < 1400; i++) begin
      @(posedge hclk);
      na += int'(set_err === 1'b1);
    end
    check_pin("setting error flashing", 1'b1, na > 0 && na < 1400);
    rd(ptc_pkg::A_ISTAT, 32'h4, "int_stat");
    repeat (2) @(posedge hclk);
    check_pin("irq", 1'b0, irq);
    wr(ptc_pkg::A_FREF, 32'h2, 1'b1);
    rd(ptc_pkg::A_FREF, 32'h0, "freq_ref");
    check_pin("irq", 1'b1, irq);
    rd(ptc_pkg::A_ISTAT, 32'h8, "int_stat");
    wr(ptc_pkg::A_CLR, 32'h2);
    rd(ptc_pkg::A_STAT, 32'h0, "status");
    wr(ptc_pkg::A_IMASK, 32'h0);
    wr(ptc_pkg::A_FREF, 32'h3);
    check_pin("irq masked", 1'b0, irq);
    rd(ptc_pkg::A_ISTAT, 32'h4, "int_stat");
    wr(ptc_pkg::A_CLR, 32'h2);
    wr(ptc_pkg::A_FREF, 32'h5);
    rd(ptc_pkg::A_FREF, 32'h5, "freq_ref");
    wr(ptc_pkg::A_PIDF, 32'h3);
    wr(ptc_pkg::A_PIDS, 32'h1);
    for (int f = 0; f <= 2; f++) begin
      wr(ptc_pkg::A_PIDF, 32'(f));
      rd(ptc_pkg::A_PIDF, 32'h3, "pid_feedback_source");
    end
    // build the full combination before protection is switched on
    wr(ptc_pkg::A_PROT, 32'h0);
    wr(ptc_pkg::A_PIDS, 32'h0);
    wr(ptc_pkg::A_PIDF, 32'h1);
    wr(ptc_pkg::A_FREF, 32'h2);
    wr(ptc_pkg::A_PIDS, 32'h1);
    wr(ptc_pkg::A_PROT, 32'h1);
    rd(ptc_pkg::A_PROT, 32'h0, "prot_sel");
    wr(ptc_pkg::A_PIDS, 32'h0);
    wr(ptc_pkg::A_PROT, 32'h1);
    rd(ptc_pkg::A_PROT, 32'h1, "prot_sel");
    wr(ptc_pkg::A_FILT, 32'h65);
    rd(ptc_pkg::A_FILT, 32'h0, "filt_time");
    wr(ptc_pkg::A_FILT, 32'h64);
    rd(ptc_pkg::A_FILT, 32'h64, "filt_time");
    wr(6'h28, $urandom());
    rd(6'h28, 32'h0, "unmapped");
////////////////////////////////////////////////////////////////////////////////
    check_pin("fan idle", 1'b0, fan_on);
    drive_running <= 1'b1;
    repeat (4) @(posedge hclk);
    check_pin("fan running", 1'b1, fan_on);
    drive_running <= 1'b0;
    repeat (HOLD_CYC - 4 * TICK) @(posedge hclk);
    check_pin("fan run-on", 1'b1, fan_on);
    repeat (8 * TICK) @(posedge hclk);
    check_pin("fan after run-on", 1'b0, fan_on);
    wr(ptc_pkg::A_FAN, 32'h1);
    repeat (4) @(posedge hclk);
    check_pin("fan always", 1'b1, fan_on);
    give_verdict();
  end
endmodule
